// ---- shared/cca_defines.vh ----
// Purpose: constants for the clear channel assessment block
// Assumes: 8-bit register port, 125 MHz digital clock
// Notes: time figures kept in their own units, cycle counts derived
`ifndef CCA_DEFINES_VH
`define CCA_DEFINES_VH
`define CCA_REG_STATUS 6'h01
`define CCA_REG_CHAN_CTRL 6'h08
`define CCA_REG_THRESHOLD 6'h09
`define CCA_REG_RX_SYNC 6'h15
`define ASSESSMENT_COMPLETE_FLAG_BIT 7
`define CCA_IDLE_BIT 6
`define CCA_START_BIT 7
`define ASSESSMENT_MODE_SELECT_HI 6
`define ASSESSMENT_MODE_SELECT_LO 5
`define CCA_PDT_DIS_BIT 7
`define ASSESSMENT_MODE_SELECT_RESET 2'h1
`define CCA_CHAN_RESET 5'h0b
`define THRESHOLD_REGISTER_HI_RESET 4'hc
`define THRESHOLD_REGISTER_RESET 4'h7
`define ASSESSMENT_MODE_SELECT_OR 2'h0
`define ASSESSMENT_MODE_SELECT_ED 2'h1
`define ASSESSMENT_MODE_SELECT_CS 2'h2
`define ASSESSMENT_MODE_SELECT_AND 2'h3
`define CCA_STATE_RX_ON 5'h06
`define CCA_STATE_BUSY_RX 5'h01
`define CCA_CLK_MHZ 125
`define CCA_SYMBOL_NS 16000
`define CCA_SYMBOLS 8
`define CCA_SYMBOL_CYCLES ((`CCA_SYMBOL_NS * `CCA_CLK_MHZ) / 1000)
`define CCA_RESULT_MAX_US 180
`define CCA_RESULT_MAX_CYCLES (`CCA_RESULT_MAX_US * `CCA_CLK_MHZ)
`define CCA_ED_STEP_DB 2
`endif

// ---- design/cca_symbol_timer.v ----
// Purpose: symbol-period enable divider and symbol counter
// Assumes: one clock, synchronous active-low reset
// Notes: restart reloads the count so a window always spans whole symbols
`timescale 1ns/10ps
`default_nettype none
`include "cca_defines.vh"
module cca_symbol_timer #(
   parameter SYMBOL_CYCLES = `CCA_SYMBOL_CYCLES,
   parameter SYMBOLS = `CCA_SYMBOLS
) (
   input wire ref_clk,
   input wire rst_b,
   input wire restart,
   input wire run,
   output reg window_end
);
   reg [11:0] cyc;
   reg [3:0] sym;
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         cyc <= 12'h000;
         sym <= 4'h0;
         window_end <= 1'b0;
      end else if (restart || !run) begin
         cyc <= 12'h000;
         sym <= 4'h0;
         window_end <= 1'b0;
      end else begin
         window_end <= 1'b0;
         if (cyc == SYMBOL_CYCLES - 1) begin
            cyc <= 12'h000;
            if (sym == SYMBOLS - 1) begin
               sym <= 4'h0;
               window_end <= 1'b1;
            end else begin
               sym <= sym + 4'h1;
            end
         end else begin
            cyc <= cyc + 12'h001;
         end
      end
   end
endmodule // cca_symbol_timer
`default_nettype wire

// ---- design/cca_core.v ----
// Purpose: clear channel assessment: request, evaluation window, flags and register port
// Assumes: radio state, carrier detect, energy level and sync-header events come from the receiver
// Notes: energy engine and radio state machine live outside; this block only judges the channel
`timescale 1ns/10ps
`default_nettype none
`include "cca_defines.vh"
// What this block does
// - mode 1: busy when any energy exceeds the threshold
// - mode 2: busy only on a compliant carrier, any strength
// - mode 0 ORs carrier and energy; mode 3 ANDs them
// - basic mode, receive state: writing start bit begins a measurement
// - eight symbols (128us) window, result within 180us of request except while waiting on an automated energy run
// - every manual assessment ends with the measure-done pulse
// - threshold is floor reference plus 2 dB per field step
// - a new request clears the complete and idle flags
// - complete flag set when the measurement cycle ends
// - idle flag one if nothing detected, else zero
// - carrier modes flag busy on a mode-specific signal above floor
// - request outside receive states: done pulse and flag, no measurement
// - receive-listen: eight symbols, result on done pulse or flag
// - receive-busy: mode 2 immediate; others wait only while an automated energy run is active, else immediate
// - one automated energy run per frame after sync header
// - status: complete bit 7, idle bit 6, bit 5 zero, state 4:0
// - start bit reads zero and clears itself
// - mode select at bits 6:5, resets to mode 1
// - energy threshold field resets to 0x7
module cca_core #(
   parameter SYMBOL_CYCLES = `CCA_SYMBOL_CYCLES,
   parameter SYMBOLS = `CCA_SYMBOLS
) (
   input wire ref_clk,
   input wire rst_b,
   input wire [5:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   input wire [4:0] radio_state_code,
   input wire extended_mode,
   input wire carrier_detect,
   input wire [7:0] energy_level,
   input wire sync_header,
   input wire auto_ed_done,
   output reg measure_done_interrupt,
   output reg preamble_detect_disable,
   output reg [4:0] channel
);
   localparam ST_IDLE = 2'h0;
   localparam ST_LISTEN = 2'h1;
   localparam ST_WAIT_ED = 2'h2;

   reg [1:0] state;
   reg [1:0] assessment_mode_select;
   reg [3:0] energy_threshold_field;
   reg [3:0] thres_hi;
   reg [6:0] rx_sync_low;
   reg assessment_complete_flag;
   reg channel_idle_flag;
   reg busy_seen;
   reg auto_ed_running;
   reg auto_ed_used;
   wire window_end;

   // energy codes are 1 dB per step; the field counts 2 dB steps
   function energy_busy;
      input [7:0] level;
      input [3:0] thres;
      begin
         energy_busy = level > ({4'h0, thres} * `CCA_ED_STEP_DB);
      end
   endfunction

   function judge_busy;
      input [1:0] mode;
      input cs;
      input ed;
      begin
         case (mode)
            `ASSESSMENT_MODE_SELECT_OR: judge_busy = cs | ed;
            `ASSESSMENT_MODE_SELECT_ED: judge_busy = ed;
            `ASSESSMENT_MODE_SELECT_CS: judge_busy = cs;
            `ASSESSMENT_MODE_SELECT_AND: judge_busy = cs & ed;
            default: judge_busy = 1'b0;
         endcase
      end
   endfunction

   wire start_wr = reg_wr && reg_addr == `CCA_REG_CHAN_CTRL && reg_wdata[`CCA_START_BIT];
   wire in_rx = radio_state_code == `CCA_STATE_RX_ON || radio_state_code == `CCA_STATE_BUSY_RX;
   wire valid_req = in_rx && !extended_mode;
   wire now_busy = judge_busy(assessment_mode_select, carrier_detect,
      energy_busy(energy_level, energy_threshold_field));
   // the request write also sets the mode, so an immediate result must judge with the written mode
   wire [1:0] req_mode = reg_wdata[`ASSESSMENT_MODE_SELECT_HI:`ASSESSMENT_MODE_SELECT_LO];
   wire req_busy = judge_busy(req_mode, carrier_detect,
      energy_busy(energy_level, energy_threshold_field));

   cca_symbol_timer #(
      .SYMBOL_CYCLES(SYMBOL_CYCLES),
      .SYMBOLS(SYMBOLS)
   ) u_timer (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .restart(start_wr),
      .run(state == ST_LISTEN),
      .window_end(window_end)
   );

   // one automated energy run per frame, started by the sync header
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         auto_ed_running <= 1'b0;
         auto_ed_used <= 1'b0;
      end else begin
         if (radio_state_code != `CCA_STATE_BUSY_RX) begin
            auto_ed_used <= 1'b0;
            auto_ed_running <= 1'b0;
         end else if (sync_header && !auto_ed_used) begin
            auto_ed_running <= 1'b1;
            auto_ed_used <= 1'b1;
         end else if (auto_ed_done) begin
            auto_ed_running <= 1'b0;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         assessment_complete_flag <= 1'b0;
         channel_idle_flag <= 1'b0;
         busy_seen <= 1'b0;
         measure_done_interrupt <= 1'b0;
      end else begin
         measure_done_interrupt <= 1'b0;
         if (start_wr) begin
            assessment_complete_flag <= 1'b0;
            channel_idle_flag <= 1'b0;
            busy_seen <= 1'b0;
            if (!valid_req) begin
               // no measurement, but software still sees completion
               assessment_complete_flag <= 1'b1;
               measure_done_interrupt <= 1'b1;
               state <= ST_IDLE;
            end else if (radio_state_code == `CCA_STATE_RX_ON) begin
               state <= ST_LISTEN;
            end else if (req_mode == `ASSESSMENT_MODE_SELECT_CS || !auto_ed_running) begin
               channel_idle_flag <= !req_busy;
               assessment_complete_flag <= 1'b1;
               measure_done_interrupt <= 1'b1;
               state <= ST_IDLE;
            end else begin
               state <= ST_WAIT_ED;
            end
         end else begin
            case (state)
               ST_LISTEN: begin
                  if (now_busy) begin
                     busy_seen <= 1'b1;
                  end
                  if (window_end) begin
                     channel_idle_flag <= !(busy_seen || now_busy);
                     assessment_complete_flag <= 1'b1;
                     measure_done_interrupt <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
               ST_WAIT_ED: begin
                  if (!auto_ed_running) begin
                     channel_idle_flag <= !now_busy;
                     assessment_complete_flag <= 1'b1;
                     measure_done_interrupt <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // control registers; the start bit is never stored
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         assessment_mode_select <= `ASSESSMENT_MODE_SELECT_RESET;
         channel <= `CCA_CHAN_RESET;
         energy_threshold_field <= `THRESHOLD_REGISTER_RESET;
         thres_hi <= `THRESHOLD_REGISTER_HI_RESET;
         preamble_detect_disable <= 1'b0;
         rx_sync_low <= 7'h00;
      end else if (reg_wr) begin
         if (reg_addr == `CCA_REG_CHAN_CTRL) begin
            assessment_mode_select <= reg_wdata[`ASSESSMENT_MODE_SELECT_HI:`ASSESSMENT_MODE_SELECT_LO];
            channel <= reg_wdata[4:0];
         end
         if (reg_addr == `CCA_REG_THRESHOLD) begin
            thres_hi <= reg_wdata[7:4];
            energy_threshold_field <= reg_wdata[3:0];
         end
         if (reg_addr == `CCA_REG_RX_SYNC) begin
            preamble_detect_disable <= reg_wdata[`CCA_PDT_DIS_BIT];
            rx_sync_low <= reg_wdata[6:0];
         end
      end
   end

   always @(posedge ref_clk) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            `CCA_REG_STATUS: reg_rdata <= {assessment_complete_flag, channel_idle_flag, 1'b0,
               radio_state_code};
            `CCA_REG_CHAN_CTRL: reg_rdata <= {1'b0, assessment_mode_select, channel};
            `CCA_REG_THRESHOLD: reg_rdata <= {thres_hi, energy_threshold_field};
            `CCA_REG_RX_SYNC: reg_rdata <= {preamble_detect_disable, rx_sync_low};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule // cca_core
`default_nettype wire

// ---- bench/cca_chk_assertions.sv ----
// Purpose: port checks for cca_core
// Assumes: one clock, synchronous active-low reset
// Notes: window bound scales with the timer parameters
`timescale 1ns/10ps
`default_nettype none
`include "cca_defines.vh"
module cca_chk #(parameter SYMBOL_CYCLES = 4, parameter SYMBOLS = 8) (
   input wire ref_clk,
   input wire rst_b,
   input wire [5:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire [4:0] radio_state_code,
   input wire extended_mode,
   input wire measure_done_interrupt
);
   localparam int LIM = SYMBOL_CYCLES * SYMBOLS + 3;
   wire req = reg_wr && reg_addr == `CCA_REG_CHAN_CTRL && reg_wdata[7];
   wire ok_st = !extended_mode && (radio_state_code == `CCA_STATE_RX_ON || radio_state_code == `CCA_STATE_BUSY_RX);
   logic pend;
   int wait_cnt;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // counts cycles a request, accepted or refused, has waited for its done pulse
   always @(posedge ref_clk) begin
      pend <= rst_b && (req || (pend && !measure_done_interrupt));
      wait_cnt <= (rst_b && pend && !req) ? wait_cnt + 1 : 0;
   end
   a_done_pulse: assert property (measure_done_interrupt |=> !measure_done_interrupt)
      else $error("done pulse longer than one cycle");
   a_bad_state: assert property (req && !ok_st |=> measure_done_interrupt)
      else $error("request outside receive states not completed");
   a_cs_now: assert property (req && ok_st && radio_state_code == `CCA_STATE_BUSY_RX && reg_wdata[6:5] == `ASSESSMENT_MODE_SELECT_CS
      |=> measure_done_interrupt) else $error("carrier mode in busy not immediate");
   a_listen_wait: assert property (req && ok_st && radio_state_code == `CCA_STATE_RX_ON
      |=> !measure_done_interrupt [*8]) else $error("listen result too early");
   a_win_bound: assert property (wait_cnt <= LIM)
      else $error("result later than window bound");
   a_status_read: assert property (reg_addr == `CCA_REG_STATUS
      |=> reg_rdata[5:0] == {1'b0, $past(radio_state_code)}) else $error("status low bits wrong");
   a_start_zero: assert property (reg_addr == `CCA_REG_CHAN_CTRL |=> !reg_rdata[7])
      else $error("start bit read back as one");
   a_req_clears: assert property (req && ok_st && radio_state_code == `CCA_STATE_RX_ON ##2 reg_addr == `CCA_REG_STATUS
      |=> reg_rdata[7:6] == 2'b00) else $error("flags not cleared by request");
   cover property (req && ok_st && radio_state_code == `CCA_STATE_RX_ON);
   cover property (req && !ok_st);
   cover property (req && radio_state_code == `CCA_STATE_BUSY_RX);
endmodule // cca_chk
bind cca_core cca_chk #(.SYMBOL_CYCLES(SYMBOL_CYCLES), .SYMBOLS(SYMBOLS)) u_chk (.ref_clk, .rst_b, .reg_addr,
   .reg_wr, .reg_wdata, .reg_rdata, .radio_state_code, .extended_mode, .measure_done_interrupt);
`default_nettype wire

// ---- bench/cca_host.sv ----
// Purpose: host register master for cca_core
// Assumes: a write is taken at the edge where reg_wr is high
// Notes: data is scrambled after a write so stale values never look valid
`timescale 1ns/10ps
`default_nettype none
module cca_host (
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   output logic [5:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_addr = 6'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // one register write: address and data driven with reg_wr high for one clock edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      @(posedge ref_clk);
      #1 d = reg_rdata;
   endtask
endmodule // cca_host
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for cca_core
// Assumes: short symbol timer, eight symbols give a 32 cycle window
// Notes: energy held steady over each window so the model stays simple
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] reg_addr;
   logic reg_wr, extended_mode = 1'b0, carrier_detect = 1'b0, sync_header = 1'b0, auto_ed_done = 1'b0;
   logic [7:0] reg_wdata, reg_rdata, rv, energy_level = 8'h00;
   logic [4:0] radio_state_code = 5'h00, channel;
   logic measure_done_interrupt, preamble_detect_disable;
   int bad_count = 0, checks = 0, n, thr, md, cs, lvl;
   always #4 ref_clk = ~ref_clk;
   cca_core #(.SYMBOL_CYCLES(4), .SYMBOLS(8)) dut (.ref_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
      .radio_state_code, .extended_mode, .carrier_detect, .energy_level, .sync_header, .auto_ed_done,
      .measure_done_interrupt, .preamble_detect_disable, .channel);
   cca_host host (.ref_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata);
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_irq();
      n = 0;
      while (measure_done_interrupt !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 200) begin
         cmp("timeout", 8'h00, 8'h01);
         conclude();
      end
   endtask
   function automatic int busy_of(input int mode, input int c, input int e, input int t);
      int ed = e > 2 * t;
      case (mode)
         0: return c | ed;
         1: return ed;
         2: return c;
         default: return c & ed;
      endcase
   endfunction
   task automatic assess(input int mode, input logic idle);
      host.wr(6'h08, {1'b1, mode[1:0], 5'h0b});
      wait_irq();
      host.rd(6'h01, rv);
      cmp("status", {1'b1, idle, 1'b0, radio_state_code}, rv);
   endtask
   initial begin
      void'($urandom(32'h58942388));
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      host.rd(6'h01, rv);
      cmp("status", 8'h00, rv);
      host.rd(6'h08, rv);
      cmp("chan_ctrl", 8'h2b, rv);
      host.rd(6'h09, rv);
      cmp("threshold", 8'hc7, rv);
      host.rd(6'h3f, rv);
      cmp("unmapped", 8'h00, rv);
      // last pass is listen state under extended mode, still refused
      for (int m = 0; m < 4; m++) begin
         radio_state_code <= (m == 3) ? 5'h06 : 5'h08;
         extended_mode <= (m == 3);
         assess(m, 1'b0);
         cmp("invalid_lat", 8'h01, n[7:0]);
      end
      extended_mode <= 1'b0;
      radio_state_code <= 5'h06;
      host.wr(6'h15, 8'h80);
      for (int i = 0; i < 16; i++) begin
         thr = 1 + $urandom % 15;
         md = i % 4;
         cs = $urandom % 2;
         lvl = 2 * thr - 1 + $urandom % 3;
         carrier_detect <= cs[0];
         energy_level <= lvl[7:0];
         host.wr(6'h09, {4'hc, thr[3:0]});
         assess(md, busy_of(md, cs, lvl, thr) == 0);
         cmp("window", 8'h01, {7'h0, n >= 32 && n <= 34});
         host.rd(6'h08, rv);
         cmp("chan_ctrl", {1'b0, md[1:0], 5'h0b}, rv);
         host.wr(6'h08, {1'b1, md[1:0], 5'h0b});
         host.rd(6'h01, rv);
         cmp("cleared", 8'h06, rv);
         wait_irq();
      end
      cmp("hold", 8'h01, {7'h0, preamble_detect_disable});
      host.wr(6'h15, 8'h00);
      radio_state_code <= 5'h01;
      carrier_detect <= 1'b1;
      assess(2, 1'b0);
      cmp("cs_lat", 8'h01, n[7:0]);
      carrier_detect <= 1'b0;
      energy_level <= 8'h00;
      @(posedge ref_clk);
      sync_header <= 1'b1;
      @(posedge ref_clk);
      sync_header <= 1'b0;
      host.wr(6'h08, 8'hab);
      repeat (6) @(posedge ref_clk);
      cmp("waiting", 8'h00, {7'h0, measure_done_interrupt});
      auto_ed_done <= 1'b1;
      @(posedge ref_clk);
      auto_ed_done <= 1'b0;
      wait_irq();
      cmp("run_lat", 8'h01, {7'h0, n <= 2});
      assess(1, 1'b1);
      cmp("after_lat", 8'h01, n[7:0]);
      cmp("channel", 8'h0b, {3'h0, channel});
      conclude();
   end
endmodule // testbench
`default_nettype wire
